// >>> rtl/cpu8_pkg.sv
// package: opcodes, timing, decode and carrier types of the 8-bit executor
package cpu8_pkg;
  // flag positions in the program status word
  localparam int F_N = 7;
  localparam int F_V = 6;
  localparam int F_G = 5;
  localparam int F_H = 3;
  localparam int F_Z = 1;
  localparam int F_C = 0;

  // reset values, stack page and page-call page
  localparam logic [7:0]  PSW_RST = 8'h00;
  localparam logic [7:0]  SP_RST  = 8'hFF;
  localparam logic [7:0]  REG_RST = 8'h00;
  localparam logic [7:0]  STK_PG  = 8'h00;
  localparam logic [7:0]  UP_PG   = 8'hFF;

  // opcode low nibbles of the regular groups
  localparam logic [3:0] LO_IMM = 4'h4;
  localparam logic [3:0] LO_DP  = 4'h5;
  localparam logic [3:0] LO_ACC = 4'h8;
  localparam logic [3:0] LO_MEM = 4'h9;
  localparam logic [3:0] LO_TC  = 4'hA;

  // operation field op[7:5] of the accumulator groups
  localparam logic [2:0] ALU_ADC = 3'd0;
  localparam logic [2:0] ALU_SBC = 3'd1;
  localparam logic [2:0] ALU_CMP = 3'd2;
  localparam logic [2:0] ALU_OR  = 3'd3;
  localparam logic [2:0] ALU_AND = 3'd4;
  localparam logic [2:0] ALU_EOR = 3'd5;
  localparam logic [2:0] ALU_LD  = 3'd6;
  localparam logic [2:0] ALU_ST  = 3'd7;
  localparam logic [2:0] SH_ASL  = 3'd0;
  localparam logic [2:0] SH_ROL  = 3'd1;
  localparam logic [2:0] SH_LSR  = 3'd2;
  localparam logic [2:0] SH_ROR  = 3'd3;
  localparam logic [2:0] SH_INC  = 3'd4;
  localparam logic [2:0] SH_DEC  = 3'd5;

  // individually decoded opcodes
  localparam logic [7:0] OP_LDM  = 8'hE4;
  localparam logic [7:0] OP_CPXI = 8'h5E;
  localparam logic [7:0] OP_CPYI = 8'h7E;
  localparam logic [7:0] OP_LDXI = 8'h1E;
  localparam logic [7:0] OP_LDYI = 8'h3E;
  localparam logic [7:0] OP_LDXD = 8'hCC;
  localparam logic [7:0] OP_STXD = 8'hEC;
  localparam logic [7:0] OP_TXA  = 8'hC8;
  localparam logic [7:0] OP_TAX  = 8'hE8;
  localparam logic [7:0] OP_TAY  = 8'h9F;
  localparam logic [7:0] OP_TYA  = 8'hBF;
  localparam logic [7:0] OP_INCX = 8'h8F;
  localparam logic [7:0] OP_DECX = 8'hAF;
  localparam logic [7:0] OP_INCY = 8'h9E;
  localparam logic [7:0] OP_DECY = 8'hBE;
  localparam logic [7:0] OP_MUL  = 8'h5B;
  localparam logic [7:0] OP_DIV  = 8'h9B;
  localparam logic [7:0] OP_DAA  = 8'hDF;
  localparam logic [7:0] OP_DAS  = 8'hCF;
  localparam logic [7:0] OP_XCN  = 8'hCE;
  localparam logic [7:0] OP_TST  = 8'h4C;
  localparam logic [7:0] OP_COM  = 8'h2C;
  localparam logic [7:0] OP_LDAP = 8'hDB;
  localparam logic [7:0] OP_STAP = 8'hFB;
  localparam logic [7:0] OP_SP_TO_X = 8'hAE;
  localparam logic [7:0] OP_X_TO_SP = 8'h8E;
  localparam logic [7:0] OP_XAX  = 8'hEE;
  localparam logic [7:0] OP_XAY  = 8'hDE;
  localparam logic [7:0] OP_XYX  = 8'hFE;
  localparam logic [7:0] OP_XMAD = 8'hBC;
  localparam logic [7:0] OP_XMAX = 8'hBB;
  localparam logic [7:0] OP_WORD_ADD = 8'h1D;
  localparam logic [7:0] OP_WORD_COMPARE = 8'h5D;
  localparam logic [7:0] OP_WORD_PLUS_ONE = 8'h9D;
  localparam logic [7:0] OP_WORD_MINUS_ONE = 8'hBD;
  localparam logic [7:0] OP_WORD_LOAD = 8'h7D;
  localparam logic [7:0] OP_WORD_STORE = 8'hDD;
  localparam logic [7:0] OP_PCAL = 8'h4F;

  // instruction cycle counts, one clock per instruction cycle
  localparam logic [3:0] CYC_2  = 4'd2;
  localparam logic [3:0] CYC_3  = 4'd3;
  localparam logic [3:0] CYC_4  = 4'd4;
  localparam logic [3:0] CYC_5  = 4'd5;
  localparam logic [3:0] CYC_6  = 4'd6;
  localparam logic [3:0] CYC_8  = 4'd8;
  localparam logic [3:0] CYC_9  = 4'd9;
  localparam logic [3:0] CYC_12 = 4'd12;

  typedef enum logic [2:0] {AM_NONE, AM_DP, AM_IX, AM_VEC, AM_STK} amode_t;
  typedef enum logic [2:0] {S_OP, S_ARG, S_RD, S_PAD, S_EX, S_WR} state_t;

  typedef struct packed {
    amode_t     am;
    logic [1:0] nargs;
    logic [1:0] nrd;
    logic [1:0] nwr;
    logic [3:0] cyc;
  } dec_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } mem_req_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  sp;
    logic [7:0]  program_status_word;
    logic [7:0]  y;
    logic [7:0]  x;
    logic [7:0]  a;
  } cpu_regs_t;
endpackage : cpu8_pkg

// >>> rtl/cpu8_instruction_executor.sv
// multicycle decode and execute core of the 8-bit controller
// Behaviour
// - add with carry into A, flags NVHZC
// - subtract with inverted carry, flags NVHZC
// - AND, OR, XOR into A, only N Z
// - compare A, flags NZC, A kept
// - compare X or Y, flags NZC only
// - zero-fill shifts of A or memory, NZC
// - rotates through carry of A or memory
// - increment or decrement, flags N Z
// - multiply into Y:A, divide Y:A by X
// - decimal adjust A after add or subtract
// - swap nibbles of A, flags N Z
// - test direct byte, complement direct byte
// - loads of A X Y set N Z
// - stores of A X Y keep flags
// - X indirect load and store of A then X plus one
// - immediate byte written to direct page
// - stack pointer to and from X
// - register swaps keep flags, memory swap NZ
// - sixteen-bit add to Y:A without carry
// - word compare, word increment and decrement
// - word load sets N Z, store keeps
// - address ranges of page and table calls
module cpu8_instruction_executor
  import cpu8_pkg::*;
#(
  parameter logic [15:0] PC_RST   = 16'hE000,
  parameter logic [15:0] TBL_BASE = 16'hFFC0
) (
  // clock and reset
  input  wire logic      clk_in,
  input  wire logic      nrst_in,
  // memory port
  output mem_req_t       mem_req_out,
  input  wire logic [7:0] mem_rdata_in,
  // state view
  output logic           fetch_out,
  output cpu_regs_t      regs_out
);
  state_t      state_ff, nxt_state;
  logic [3:0]  cnt_ff;
  logic [1:0]  idx_ff;
  logic        pend_ff;
  logic [7:0]  op_ff, arg0_ff, arg1_ff, rd0_ff, rd1_ff, wb_ff;
  logic [7:0]  a_ff, x_ff, y_ff, sp_ff, psw_ff;
  logic [15:0] pc_ff;
  logic [7:0]  n_a, n_x, n_y, n_sp, n_psw, w0, w1, opd, v8, r8;
  logic [15:0] n_pc, ya, wd, r16, quo, rem, dvs, rbase, wbase;
  logic [10:0] lo11, hi11;
  logic        jmp, do_ex, go_tail, c1;
  logic [3:0]  cnt_nxt, tail_at;
  dec_t        dc, cs;

  // fields of one opcode: addressing, lengths, cycle count
  function automatic dec_t decode(input logic [7:0] op);
    dec_t d;
    d = '{AM_NONE, 2'd0, 2'd0, 2'd0, CYC_2};
    if (op == OP_LDM) begin
      d = '{AM_DP, 2'd2, 2'd0, 2'd1, CYC_5};
    end else if (op[3:0] == LO_IMM && !op[4]) begin
      d = '{AM_NONE, 2'd1, 2'd0, 2'd0, CYC_2};
    end else if (op[3:0] == LO_IMM || (op[3:0] == LO_DP && !op[4])) begin
      d.am    = op[4] ? AM_IX : AM_DP;
      d.nargs = op[4] ? 2'd0 : 2'd1;
      d.nrd   = (op[7:5] == ALU_ST) ? 2'd0 : 2'd1;
      d.nwr   = (op[7:5] == ALU_ST) ? 2'd1 : 2'd0;
      d.cyc   = (op[7:5] == ALU_ST) ? CYC_4 : CYC_3;
    end else if (op[3:0] == LO_MEM && !op[4]) begin
      d.am    = AM_DP;
      d.nargs = 2'd1;
      d.nrd   = (op[7:5] == ALU_ST) ? 2'd0 : 2'd1;
      d.nwr   = (op[7:5] == ALU_LD) ? 2'd0 : 2'd1;
      d.cyc   = (op[7:5] == ALU_LD) ? CYC_3 : CYC_4;
    end else if (op[3:0] == LO_TC) begin
      d = '{AM_VEC, 2'd0, 2'd2, 2'd2, CYC_8};
    end else begin
      case (op)
        OP_CPXI, OP_CPYI, OP_LDXI, OP_LDYI: d.nargs = 2'd1;
        OP_LDXD: d = '{AM_DP, 2'd1, 2'd1, 2'd0, CYC_3};
        OP_STXD: d = '{AM_DP, 2'd1, 2'd0, 2'd1, CYC_4};
        OP_TST:  d = '{AM_DP, 2'd1, 2'd1, 2'd0, CYC_3};
        OP_COM:  d = '{AM_DP, 2'd1, 2'd1, 2'd1, CYC_4};
        OP_MUL:  d.cyc = CYC_9;
        OP_DIV:  d.cyc = CYC_12;
        OP_DAA, OP_DAS: d.cyc = CYC_3;
        OP_XCN:  d.cyc = CYC_5;
        OP_XAX, OP_XAY, OP_XYX: d.cyc = CYC_4;
        OP_LDAP: d = '{AM_IX, 2'd0, 2'd1, 2'd0, CYC_4};
        OP_STAP: d = '{AM_IX, 2'd0, 2'd0, 2'd1, CYC_4};
        OP_XMAD: d = '{AM_DP, 2'd1, 2'd1, 2'd1, CYC_5};
        OP_XMAX: d = '{AM_IX, 2'd0, 2'd1, 2'd1, CYC_5};
        OP_WORD_ADD, OP_WORD_LOAD: d = '{AM_DP, 2'd1, 2'd2, 2'd0, CYC_5};
        OP_WORD_COMPARE: d = '{AM_DP, 2'd1, 2'd2, 2'd0, CYC_4};
        OP_WORD_PLUS_ONE, OP_WORD_MINUS_ONE: d = '{AM_DP, 2'd1, 2'd2, 2'd2, CYC_6};
        OP_WORD_STORE: d = '{AM_DP, 2'd1, 2'd0, 2'd2, CYC_5};
        OP_PCAL: d = '{AM_STK, 2'd1, 2'd0, 2'd2, CYC_6};
        default: d.cyc = CYC_2;
      endcase
    end
    return d;
  endfunction : decode

  // 8-bit adder: {carry, half carry, overflow, sum}
  function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
    logic [4:0] lo;
    logic [8:0] s;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'd0, ci};
    s  = {1'b0, a} + {1'b0, b} + {8'd0, ci};
    return {s[8], lo[4], (a[7] == b[7]) && (s[7] != a[7]), s[7:0]};
  endfunction : add8

  // N and Z from a result, other flags kept
  function automatic logic [7:0] fl_nz(input logic [7:0] p, input logic n, input logic z);
    logic [7:0] q;
    q      = p;
    q[F_N] = n;
    q[F_Z] = z;
    return q;
  endfunction : fl_nz

  assign dc      = decode(op_ff);
  assign cs      = (state_ff == S_OP) ? decode(mem_rdata_in) : dc;
  assign ya      = {y_ff, a_ff};
  assign wd      = {rd1_ff, rd0_ff};
  assign opd     = (dc.nrd != 2'd0) ? rd0_ff : arg0_ff;
  assign dvs     = (x_ff == 8'h00) ? 16'h0001 : {8'h00, x_ff};
  assign quo     = (x_ff == 8'h00) ? 16'hFFFF : ya / dvs;
  assign rem     = (x_ff == 8'h00) ? {8'h00, y_ff} : ya % dvs;
  assign do_ex   = (state_ff == S_EX) || (state_ff == S_OP && pend_ff);
  assign cnt_nxt = (state_ff == S_OP) ? 4'd1 : cnt_ff + 4'd1;
  assign tail_at = cs.cyc - {2'b00, cs.nwr};
  assign go_tail = (cnt_nxt == tail_at);

  // read and write base addresses
  always_comb begin
    case (dc.am)
      AM_IX:   rbase = {7'd0, psw_ff[F_G], x_ff};
      AM_VEC:  rbase = TBL_BASE + {11'd0, op_ff[7:4], 1'b0};
      default: rbase = {7'd0, psw_ff[F_G], arg0_ff};
    endcase
    wbase = (dc.am == AM_VEC || dc.am == AM_STK) ? {STK_PG, sp_ff} : rbase;
  end

  // sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      S_OP, S_ARG: begin
        if (state_ff == S_OP && cs.nargs != 2'd0) begin
          nxt_state = S_ARG;
        end else if (state_ff == S_ARG && idx_ff != cs.nargs - 2'd1) begin
          nxt_state = S_ARG;
        end else if (cs.nrd != 2'd0) begin
          nxt_state = S_RD;
        end else begin
          nxt_state = go_tail ? (cs.nwr != 2'd0 ? S_EX : S_OP) : S_PAD;
        end
      end
      S_RD: begin
        if (idx_ff != cs.nrd - 2'd1) begin
          nxt_state = S_RD;
        end else begin
          nxt_state = go_tail ? (cs.nwr != 2'd0 ? S_EX : S_OP) : S_PAD;
        end
      end
      S_PAD:   nxt_state = go_tail ? (cs.nwr != 2'd0 ? S_EX : S_OP) : S_PAD;
      S_EX:    nxt_state = (cs.nwr == 2'd2) ? S_WR : S_OP;
      S_WR:    nxt_state = S_OP;
      default: nxt_state = S_OP;
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_ff <= S_OP;
      cnt_ff   <= 4'd0;
      idx_ff   <= 2'd0;
      pend_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= cnt_nxt;
      idx_ff   <= (nxt_state == state_ff) ? idx_ff + 2'd1 : 2'd0;
      pend_ff  <= (nxt_state == S_OP) && (state_ff != S_EX) && (state_ff != S_WR);
    end
  end

  // opcode, operand and read capture
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      op_ff   <= REG_RST;
      arg0_ff <= REG_RST;
      arg1_ff <= REG_RST;
      rd0_ff  <= REG_RST;
      rd1_ff  <= REG_RST;
      wb_ff   <= REG_RST;
    end else begin
      if (state_ff == S_OP) begin
        op_ff <= mem_rdata_in;
      end
      if (state_ff == S_ARG && idx_ff == 2'd0) begin
        arg0_ff <= mem_rdata_in;
      end
      if (state_ff == S_ARG && idx_ff == 2'd1) begin
        arg1_ff <= mem_rdata_in;
      end
      if (state_ff == S_RD && idx_ff == 2'd0) begin
        rd0_ff <= mem_rdata_in;
      end
      if (state_ff == S_RD && idx_ff == 2'd1) begin
        rd1_ff <= mem_rdata_in;
      end
      if (state_ff == S_EX) begin
        wb_ff <= w1;
      end
    end
  end

  // memory requests: low byte first, stack pushes write the high byte first and go downward
  // sp is already lowered by two when the second push goes out
  always_comb begin
    mem_req_out = '{pc_ff, 1'b0, 1'b0, 8'h00};
    case (state_ff)
      S_OP, S_ARG: mem_req_out.rd = 1'b1;
      S_RD:  mem_req_out = '{rbase + {14'd0, idx_ff}, 1'b1, 1'b0, 8'h00};
      S_EX:  mem_req_out = '{wbase, 1'b0, 1'b1, w0};
      S_WR:  mem_req_out = '{(dc.am == AM_STK || dc.am == AM_VEC) ? {STK_PG, sp_ff + 8'd1} : wbase + 16'd1,
                             1'b0, 1'b1, wb_ff};
      default: mem_req_out.rd = 1'b0;
    endcase
  end

  // execution results
  always_comb begin
    n_a   = a_ff;
    n_x   = x_ff;
    n_y   = y_ff;
    n_sp  = sp_ff;
    n_psw = psw_ff;
    n_pc  = pc_ff;
    jmp   = 1'b0;
    w0    = a_ff;
    w1    = y_ff;
    lo11  = add8(a_ff, ~rd0_ff, 1'b1);
    hi11  = add8(y_ff, ~rd1_ff, lo11[10]);
    v8    = op_ff[0] ? rd0_ff : a_ff;
    r8    = v8;
    r16   = wd;
    c1    = psw_ff[F_C];
    if (op_ff[3:0] == LO_IMM && op_ff != OP_LDM || op_ff[3:0] == LO_DP && !op_ff[4]) begin
      case (op_ff[7:5])
        ALU_ADC, ALU_SBC: begin
          lo11  = add8(a_ff, op_ff[5] ? ~opd : opd, psw_ff[F_C]);
          n_a   = lo11[7:0];
          n_psw = fl_nz(psw_ff, lo11[7], lo11[7:0] == 8'h00);
          n_psw[F_C] = lo11[10];
          n_psw[F_H] = lo11[9];
          n_psw[F_V] = lo11[8];
        end
        ALU_CMP: begin
          lo11  = add8(a_ff, ~opd, 1'b1);
          n_psw = fl_nz(psw_ff, lo11[7], lo11[7:0] == 8'h00);
          n_psw[F_C] = lo11[10];
        end
        ALU_OR, ALU_AND, ALU_EOR, ALU_LD: begin
          case (op_ff[7:5])
            ALU_OR:  n_a = a_ff | opd;
            ALU_AND: n_a = a_ff & opd;
            ALU_EOR: n_a = a_ff ^ opd;
            default: n_a = opd;
          endcase
          n_psw = fl_nz(psw_ff, n_a[7], n_a == 8'h00);
        end
        default: w0 = a_ff;
      endcase
    end else if ((op_ff[3:0] == LO_ACC || op_ff[3:0] == LO_MEM) && !op_ff[4] && op_ff[7:5] <= SH_DEC) begin
      case (op_ff[7:5])
        SH_ASL:  {c1, r8} = {v8, 1'b0};
        SH_ROL:  {c1, r8} = {v8, psw_ff[F_C]};
        SH_LSR:  {r8, c1} = {1'b0, v8};
        SH_ROR:  {r8, c1} = {psw_ff[F_C], v8};
        SH_INC:  r8 = v8 + 8'd1;
        default: r8 = v8 - 8'd1;
      endcase
      n_psw      = fl_nz(psw_ff, r8[7], r8 == 8'h00);
      n_psw[F_C] = c1;
      w0         = r8;
      if (!op_ff[0]) begin
        n_a = r8;
      end
    end else if (op_ff[3:0] == LO_TC || op_ff == OP_PCAL) begin
      jmp  = 1'b1;
      n_pc = (op_ff == OP_PCAL) ? {UP_PG, arg0_ff} : wd;
      n_sp = sp_ff - 8'd2;
      w0   = pc_ff[15:8];
      w1   = pc_ff[7:0];
    end else begin
      case (op_ff)
        OP_CPXI, OP_CPYI: begin
          lo11  = add8(op_ff[5] ? y_ff : x_ff, ~arg0_ff, 1'b1);
          n_psw = fl_nz(psw_ff, lo11[7], lo11[7:0] == 8'h00);
          n_psw[F_C] = lo11[10];
        end
        OP_LDXI, OP_LDXD, OP_TAX, OP_INCX, OP_DECX, OP_SP_TO_X, OP_X_TO_SP: begin
          case (op_ff)
            OP_LDXI: n_x = arg0_ff;
            OP_LDXD: n_x = rd0_ff;
            OP_TAX:  n_x = a_ff;
            OP_INCX: n_x = x_ff + 8'd1;
            OP_DECX: n_x = x_ff - 8'd1;
            OP_SP_TO_X: n_x = sp_ff;
            default: n_sp = x_ff;
          endcase
          n_psw = fl_nz(psw_ff, n_x[7], n_x == 8'h00);
        end
        OP_LDYI, OP_TAY, OP_INCY, OP_DECY: begin
          case (op_ff)
            OP_LDYI: n_y = arg0_ff;
            OP_TAY:  n_y = a_ff;
            OP_INCY: n_y = y_ff + 8'd1;
            default: n_y = y_ff - 8'd1;
          endcase
          n_psw = fl_nz(psw_ff, n_y[7], n_y == 8'h00);
        end
        8'hC9: begin
          n_y   = rd0_ff;
          n_psw = fl_nz(psw_ff, n_y[7], n_y == 8'h00);
        end
        8'hE9:   w0 = y_ff;
        OP_STXD: w0 = x_ff;
        OP_TXA, OP_TYA, OP_LDAP, OP_XCN: begin
          case (op_ff)
            OP_TXA:  n_a = x_ff;
            OP_TYA:  n_a = y_ff;
            OP_LDAP: n_a = rd0_ff;
            default: n_a = {a_ff[3:0], a_ff[7:4]};
          endcase
          if (op_ff == OP_LDAP) begin
            n_x = x_ff + 8'd1;
          end
          n_psw = fl_nz(psw_ff, n_a[7], n_a == 8'h00);
        end
        OP_STAP: n_x = x_ff + 8'd1;
        OP_MUL: begin
          {n_y, n_a} = y_ff * a_ff;
          n_psw      = fl_nz(psw_ff, n_y[7], {n_y, n_a} == 16'h0000);
        end
        OP_DIV: begin
          n_a   = quo[7:0];
          n_y   = rem[7:0];
          n_psw = fl_nz(psw_ff, n_a[7], n_a == 8'h00);
          n_psw[F_V] = quo[15:8] != 8'h00;
          n_psw[F_H] = y_ff[3:0] >= x_ff[3:0];
        end
        OP_DAA, OP_DAS: begin
          r8 = a_ff;
          c1 = psw_ff[F_C];
          if (op_ff == OP_DAA) begin
            if (psw_ff[F_C] || a_ff > 8'h99) begin
              r8 = r8 + 8'h60;
              c1 = 1'b1;
            end
            if (psw_ff[F_H] || a_ff[3:0] > 4'h9) begin
              r8 = r8 + 8'h06;
            end
          end else begin
            if (!psw_ff[F_C] || a_ff > 8'h99) begin
              r8 = r8 - 8'h60;
              c1 = 1'b0;
            end
            if (!psw_ff[F_H] || a_ff[3:0] > 4'h9) begin
              r8 = r8 - 8'h06;
            end
          end
          n_a        = r8;
          n_psw      = fl_nz(psw_ff, r8[7], r8 == 8'h00);
          n_psw[F_C] = c1;
        end
        OP_TST: n_psw = fl_nz(psw_ff, rd0_ff[7], rd0_ff == 8'h00);
        OP_COM: begin
          w0    = ~rd0_ff;
          n_psw = fl_nz(psw_ff, ~rd0_ff[7], rd0_ff == 8'hFF);
        end
        OP_LDM: w0 = arg1_ff;
        OP_XAX: {n_a, n_x} = {x_ff, a_ff};
        OP_XAY: {n_a, n_y} = {y_ff, a_ff};
        OP_XYX: {n_x, n_y} = {y_ff, x_ff};
        OP_XMAD, OP_XMAX: begin
          n_a   = rd0_ff;
          n_psw = fl_nz(psw_ff, rd0_ff[7], rd0_ff == 8'h00);
        end
        OP_WORD_ADD, OP_WORD_COMPARE: begin
          if (op_ff == OP_WORD_ADD) begin
            lo11 = add8(a_ff, rd0_ff, 1'b0);
            hi11 = add8(y_ff, rd1_ff, lo11[10]);
            {n_y, n_a} = {hi11[7:0], lo11[7:0]};
            n_psw[F_H] = hi11[9];
            n_psw[F_V] = hi11[8];
          end
          n_psw      = fl_nz(n_psw, hi11[7], {hi11[7:0], lo11[7:0]} == 16'h0000);
          n_psw[F_C] = hi11[10];
        end
        OP_WORD_PLUS_ONE, OP_WORD_MINUS_ONE: begin
          r16      = (op_ff == OP_WORD_PLUS_ONE) ? wd + 16'd1 : wd - 16'd1;
          {w1, w0} = r16;
          n_psw    = fl_nz(psw_ff, r16[15], r16 == 16'h0000);
        end
        OP_WORD_LOAD: begin
          {n_y, n_a} = wd;
          n_psw      = fl_nz(psw_ff, rd1_ff[7], wd == 16'h0000);
        end
        OP_WORD_STORE: {w1, w0} = ya;
        default: jmp = 1'b0;
      endcase
    end
  end

  // architectural registers
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      a_ff   <= REG_RST;
      x_ff   <= REG_RST;
      y_ff   <= REG_RST;
      sp_ff  <= SP_RST;
      psw_ff <= PSW_RST;
    end else if (do_ex) begin
      a_ff   <= n_a;
      x_ff   <= n_x;
      y_ff   <= n_y;
      sp_ff  <= n_sp;
      psw_ff <= n_psw;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pc_ff <= PC_RST;
    end else if (do_ex && jmp) begin
      pc_ff <= n_pc;
    end else if (state_ff == S_OP || state_ff == S_ARG) begin
      pc_ff <= pc_ff + 16'd1;
    end
  end

  assign fetch_out = (state_ff == S_OP);
  assign regs_out  = '{pc_ff, sp_ff, psw_ff, y_ff, x_ff, a_ff};
endmodule : cpu8_instruction_executor

// >>> tb/cpu8_mem_model.sv
// memory model: program and data bytes, zero-latency read
module cpu8_mem_model import cpu8_pkg::*; (
  // clock
  input  wire logic     clk_in,
  // core side
  input  wire mem_req_t mem_req_in,
  output logic [7:0]    mem_rdata_out
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_ff = 8'h00;
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
  end
  always @(posedge clk_in) begin
    if (mem_req_in.wr) mem[mem_req_in.addr] <= mem_req_in.wdata;
    if (mem_req_in.rd) last_ff <= mem_rdata_out;
  end
  // idle bus shows the inverse of the last byte
  assign mem_rdata_out = mem_req_in.rd ? mem[mem_req_in.addr] : ~last_ff;
endmodule : cpu8_mem_model

// >>> tb/cpu8_monitor.sv
// checker: timing and bus use of the executor
module cpu8_monitor import cpu8_pkg::*; (
  // clock and reset
  input wire logic       clk_in,
  input wire logic       nrst_in,
  // memory and state
  input wire mem_req_t   mem_req_out,
  input wire logic [7:0] mem_rdata_in,
  input wire logic       fetch_out,
  input wire cpu_regs_t  regs_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic [7:0] op;
  assign op = fetch_out ? mem_rdata_in : 8'h00;
  chk_adc_len: assert property (op == 8'h04 |=> !fetch_out ##1 fetch_out)
    else $error("adc length wrong");
  chk_cmp_keeps_a: assert property (op == 8'h44 |=> !fetch_out ##1 fetch_out ##1
    regs_out.a == $past(regs_out.a, 2)) else $error("compare changed a");
  chk_inc_len: assert property (op == 8'h88 |=> !fetch_out ##1 fetch_out)
    else $error("inc length wrong");
  chk_div_len: assert property (op == 8'h9B |=> !fetch_out[*8] ##1 !fetch_out[*3] ##1 fetch_out)
    else $error("div length wrong");
  chk_xcn_len: assert property (op == 8'hCE |=> !fetch_out[*4] ##1 fetch_out)
    else $error("nibble swap length wrong");
  chk_sta_dp: assert property (op == 8'hE5 |=> ##2 (mem_req_out.wr && mem_req_out.addr[15:8] == 8'h00 &&
    mem_req_out.wdata == regs_out.a) ##1 fetch_out) else $error("store write wrong");
  chk_ldm_write: assert property (op == 8'hE4 |=> ##3 (mem_req_out.wr &&
    mem_req_out.wdata == $past(mem_rdata_in, 2) && mem_req_out.addr == {8'h00, $past(mem_rdata_in, 3)})
    ##1 fetch_out) else $error("immediate store wrong");
  chk_post_inc: assert property (op == 8'hFB |=> ##2 (mem_req_out.wr &&
    mem_req_out.addr == {8'h00, regs_out.x} && mem_req_out.wdata == regs_out.a)
    ##1 regs_out.x == $past(regs_out.x) + 8'h01) else $error("post increment wrong");
  chk_swap_flags: assert property (op == 8'hEE |=> ##1 $stable(regs_out.program_status_word)[*4])
    else $error("swap changed flags");
endmodule : cpu8_monitor
bind cpu8_instruction_executor cpu8_monitor i_cpu8_monitor (.clk_in(clk_in), .nrst_in(nrst_in),
  .mem_req_out(mem_req_out), .mem_rdata_in(mem_rdata_in), .fetch_out(fetch_out), .regs_out(regs_out));

// >>> tb/tb_top.sv
// testbench: random short programs through the executor
module tb_top import cpu8_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_in = 1'b0;
  logic       nrst_in = 1'b0;
  mem_req_t   req;
  logic [7:0] rd;
  logic       fetch;
  cpu_regs_t  r;
  int         fail_count = 0;
  int         n_checks = 0;
  int         seed = 38;
  int         cyc = 0;
  logic [7:0] n, a, b, e;
  logic       c;
  logic [15:0] w;
  logic [7:0] p[$];
  logic [7:0] ops[12] = '{8'h04, 8'h24, 8'h44, 8'h84, 8'h64, 8'hA4, 8'h08, 8'h48, 8'h28, 8'h68, 8'h88, 8'hA8};
  cpu8_instruction_executor i_cpu8_instruction_executor (.clk_in(clk_in), .nrst_in(nrst_in),
    .mem_req_out(req), .mem_rdata_in(rd), .fetch_out(fetch), .regs_out(r));
  cpu8_mem_model i_cpu8_mem_model (.clk_in(clk_in), .mem_req_in(req), .mem_rdata_out(rd));
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic chk(input string s, input logic [7:0] g, input logic [7:0] x);
    n_checks++;
    if (g !== x) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", s, x, g);
    end
  endtask : chk
  // loads p at the reset address, runs it, n = length of its last instruction
  task automatic run();
    logic [15:0] en;
    logic [7:0]  k;
    logic [7:0]  t;
    en = 16'hE000 + 16'(p.size());
    foreach (p[i]) i_cpu8_mem_model.mem[16'hE000 + 16'(i)] = p[i];
    i_cpu8_mem_model.mem[en] = 8'hFF;
    nrst_in = 1'b0;
    repeat (8) @(negedge clk_in);
    nrst_in = 1'b1;
    k = 8'h00;
    t = 8'h00;
    do begin
      @(negedge clk_in);
      k++;
      if (fetch === 1'b1) begin
        n = k - t;
        t = k;
      end
    end while (!(fetch === 1'b1 && r.pc === en) && k < 8'hC8);
    @(negedge clk_in);
  endtask : run
  // {flags N..Z C, accumulator} after op with carry in
  function automatic logic [15:0] calc(input logic [7:0] op, input logic [7:0] x, input logic [7:0] y,
                                       input logic ci);
    logic [8:0] s;
    case (op)
      8'h04: s = x + y + ci;
      8'h24: s = {1'b1, x} - y - !ci;
      8'h44: s = {1'b1, x} - y;
      8'h84: s = {ci, x & y};
      8'h64: s = {ci, x | y};
      8'hA4: s = {ci, x ^ y};
      8'h08: s = {x, 1'b0};
      8'h48: s = {x[0], 1'b0, x[7:1]};
      8'h28: s = {x, ci};
      8'h68: s = {x[0], ci, x[7:1]};
      8'h88: s = {ci, x + 8'h01};
      default: s = {ci, x - 8'h01};
    endcase
    calc = {s[7], 5'h00, s[7:0] == 8'h00, s[8], op == 8'h44 ? x : s[7:0]};
  endfunction : calc
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  initial begin
    for (int i = 0; i < 48; i++) begin
      e = ops[i % 12];
      a = 8'($random(seed));
      b = (i < 12) ? a : 8'($random(seed));
      c = 1'($random(seed));
      p = '{8'hC4, 8'h80, 8'h08, 8'hC4, a, e, b};
      if (!c) p = p[3:$];
      if (!e[2]) void'(p.pop_back());
      run();
      w = calc(e, a, b, c);
      chk("acc", r.a, w[7:0]);
      chk("flags", r.program_status_word & 8'h83, w[15:8]);
      chk("len", n, 8'h02);
    end
    for (int i = 0; i < 4; i++) begin
      a = 8'($random(seed));
      b = 8'($random(seed)) | 8'h01;
      p = '{8'h3E, b, 8'hC4, a, 8'h5B};
      run();
      w = a * b;
      chk("mul_y", r.y, w[15:8]);
      chk("mul_a", r.a, w[7:0]);
      chk("mul_len", n, 8'h09);
      p = '{8'h1E, b, 8'hC4, a, 8'h9B, 8'hC4, a, 8'hCE};
      run();
      chk("div_y", r.y, a % b);
      chk("nib", r.a, {a[3:0], a[7:4]});
      chk("nib_nz", r.program_status_word & 8'h82, {a[3], 5'h00, a == 8'h00, 1'b0});
      p = '{8'hC4, a, 8'hE5, b, 8'hE4, ~b, ~a, 8'h1E, b ^ 8'h02, 8'hFB};
      run();
      chk("sta", i_cpu8_mem_model.mem[{8'h00, b}], a);
      chk("ldm", i_cpu8_mem_model.mem[{8'h00, ~b}], ~a);
      chk("sta_x", i_cpu8_mem_model.mem[{8'h00, b ^ 8'h02}], a);
      chk("x_inc", r.x, (b ^ 8'h02) + 8'h01);
      chk("st_psw", r.program_status_word, {b[7], 7'h00});
      chk("st_len", n, 8'h04);
      p = '{8'h1E, a, 8'h3E, a, 8'h7E, a};
      run();
      chk("compare_index_y", r.program_status_word, 8'h03);
      chk("compare_index_y_x", r.x, a);
      p = '{8'hC4, a, 8'h1E, b, 8'hEE, 8'hAE, 8'h00};
      run();
      chk("xax", r.a, b);
      chk("spx", r.x, 8'hFF);
      chk("spx_f", r.program_status_word, 8'h80);
      chk("nop_len", n, 8'h02);
      e = b & 8'h7E;
      i_cpu8_mem_model.mem[{8'h00, e}] = a;
      i_cpu8_mem_model.mem[{8'h00, e + 8'h01}] = ~a;
      p = '{8'h7D, e, 8'h1D, e, 8'hDD, e, 8'h9D, e};
      run();
      w = {~a, a} + {~a, a};
      chk("word_y", r.y, w[15:8]);
      chk("word_a", r.a, w[7:0]);
      w = w + 16'h0001;
      chk("word_lo", i_cpu8_mem_model.mem[{8'h00, e}], w[7:0]);
      chk("word_hi", i_cpu8_mem_model.mem[{8'h00, e + 8'h01}], w[15:8]);
      chk("word_plus_one_len", n, 8'h06);
    end
    summarize();
  end
endmodule : tb_top
